// ==== hw/bsop_top.sv ====
`timescale 1ns/100ps
`include "bsop_defines.svh"
module bsop_top
	import bsop_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        instr_valid,
	input  wire logic [31:0] instr,
	input  wire logic [31:0] instr_addr,
	input  wire logic [31:0] rn_value,
	input  wire logic [31:0] rm_value,
	input  wire logic [31:0] rs_value,
	input  wire logic [31:0] alu_result,
	input  wire logic        alu_carry,
	input  wire logic        alu_overflow,
	input  wire logic [31:0] saved_status_word,
	output logic             instr_ready,
	output logic             op_valid,
	output logic [3:0]       alu_opcode,
	output logic [31:0]      op1,
	output logic [31:0]      op2,
	output logic             shift_carry,
	output logic             rd_we,
	output logic [3:0]       rd_index,
	output logic [31:0]      rd_value,
	output logic             pc_we,
	output logic [31:0]      pc_value,
	output logic [31:0]      current_status_word,
	output logic             undef_instr,
	output logic             done,
	output logic [1:0]       cyc_seq,
	output logic             cyc_nonseq,
	output logic             cyc_internal
);
	// ----------------------------------------
	// decode helpers
	// ----------------------------------------

	// register index names the program counter
	function automatic logic is_pc(input logic [3:0] idx);
		return idx == `BSOP_PC_INDEX;
	endfunction

	// subtract, add and compare class
	function automatic logic is_arith(input logic [3:0] op);
		return (op >= 4'h2 && op <= 4'h7) || op == 4'hA || op == 4'hB;
	endfunction

	bsop_state_t state;
	bsop_state_t next_state;

	logic [31:0] instr_q;
	logic [31:0] opnd_q [2];
	logic [31:0] rs_q;

	// ----------------------------------------
	// issue decode
	// ----------------------------------------

	// fields of the arriving instruction
	wire        in_imm    = instr[`BSOP_F_IMM];
	wire        in_shreg  = ~in_imm & instr[`BSOP_F_SHREG];
	wire        in_illegal = in_shreg & instr[`BSOP_F_MULBIT];
	wire [31:0] pc_read   = instr_addr + (in_shreg ? `BSOP_PC_OFS_REG : `BSOP_PC_OFS_IMM);
	wire        accept    = instr_valid & instr_ready;

	wire [3:0]  in_idx [2];
	wire [31:0] in_raw [2];
	wire [31:0] in_opnd [2];
	assign in_idx[0] = instr[`BSOP_F_RN_HI:`BSOP_F_RN_LO];
	assign in_idx[1] = instr[`BSOP_F_RM_HI:`BSOP_F_RM_LO];
	assign in_raw[0] = rn_value;
	assign in_raw[1] = rm_value;

	// first and second operand reads of the program counter
	for (genvar g = 0; g < 2; g++) begin : g_opnd
		assign in_opnd[g] = is_pc(in_idx[g]) ? pc_read : in_raw[g];
	end

	// ----------------------------------------
	// latched instruction fields
	// ----------------------------------------

	wire        q_imm    = instr_q[`BSOP_F_IMM];
	wire        q_shreg  = ~q_imm & instr_q[`BSOP_F_SHREG];
	wire        q_set    = instr_q[`BSOP_F_SET];
	wire [3:0]  q_op     = instr_q[`BSOP_F_OP_HI:`BSOP_F_OP_LO];
	wire [3:0]  q_rd     = instr_q[`BSOP_F_RD_HI:`BSOP_F_RD_LO];
	wire [4:0]  q_amt5   = instr_q[`BSOP_F_AMT_HI:`BSOP_F_AMT_LO];
	wire [7:0]  q_amount = q_shreg ? rs_q[7:0] : {3'h0, q_amt5};
	wire        q_test   = (q_op[3:2] == 2'h2);
	wire        q_pc_dst = is_pc(q_rd);
	wire        old_c    = current_status_word[`BSOP_C];
	wire        user_mode = (current_status_word[`BSOP_MODE_HI:0] == `BSOP_MODE_USER);

	// ----------------------------------------
	// operand two generation
	// ----------------------------------------

	bsop_shift_if shl ();

	assign shl.kind     = bsop_shift_t'(instr_q[`BSOP_F_TYP_HI:`BSOP_F_TYP_LO]);
	assign shl.amount   = q_amount;
	assign shl.imm_form = ~q_shreg;
	assign shl.value    = opnd_q[1];
	assign shl.carry_in = old_c;

	bsop_shifter #(
		.W (32)
	) u_shifter (
		.sh (shl.shifter)
	);

	wire [31:0] imm_val;
	wire        imm_carry;

	bsop_imm_rot u_imm_rot (
		.imm       (instr_q[7:0]),
		.rot_field (instr_q[11:8]),
		.carry_in  (old_c),
		.value     (imm_val),
		.carry_out (imm_carry)
	);

	// operand two and its carry, same cycle as selection
	wire [31:0] sel_op2   = q_imm ? imm_val : shl.result;
	wire        sel_carry = q_imm ? imm_carry : shl.carry_out;

	// ----------------------------------------
	// flag and write-back decisions
	// ----------------------------------------

	wire        res_zero  = (alu_result == 32'h00000000);
	wire        arith_op  = is_arith(q_op);
	wire        teq_rest  = q_test & q_pc_dst & q_set & (q_op == `BSOP_OP_TEQ);
	wire        wb_pc     = q_pc_dst & ~q_test;
	wire        wb_rd     = ~q_pc_dst & ~q_test;
	wire        wb_flags  = q_set & ~q_pc_dst;
	wire        wb_restore = (wb_pc & q_set & ~user_mode) | (wb_pc & q_set & user_mode)
		| (teq_rest & ~user_mode);

	// new flag nibble from the alu and shifter
	wire        next_c    = arith_op ? alu_carry : shift_carry;
	wire        next_v    = arith_op ? alu_overflow : current_status_word[`BSOP_V];
	wire [3:0]  next_nzcv = {alu_result[31], res_zero, next_c, next_v};

	// ----------------------------------------
	// sequencer
	// ----------------------------------------

	// next state along the cycle cost path
	always_comb begin
		next_state = state;
		case (state)
			BSOP_IDLE: begin
				if (accept & ~in_illegal) begin
					next_state = in_shreg ? BSOP_RSH : BSOP_EXEC;
				end
			end
			BSOP_RSH: begin
				next_state = BSOP_EXEC;
			end
			BSOP_EXEC: begin
				next_state = BSOP_WB;
			end
			BSOP_WB: begin
				next_state = wb_pc ? BSOP_PC_S : BSOP_IDLE;
			end
			BSOP_PC_S: begin
				next_state = BSOP_PC_N;
			end
			BSOP_PC_N: begin
				next_state = BSOP_IDLE;
			end
			default: begin
				next_state = BSOP_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state <= BSOP_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------
	// issue capture
	// ----------------------------------------

	// latch instruction and operands when taken
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			instr_q   <= 32'h00000000;
			opnd_q[0] <= 32'h00000000;
			opnd_q[1] <= 32'h00000000;
			rs_q      <= 32'h00000000;
		end else if (accept) begin
			instr_q   <= instr;
			opnd_q[0] <= in_opnd[0];
			opnd_q[1] <= in_opnd[1];
			rs_q      <= rs_value;
		end
	end

	// ready only when idle and not already taking
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			instr_ready <= 1'b1;
		end else begin
			instr_ready <= (next_state == BSOP_IDLE);
		end
	end

	// bit 7 set in register-shift form is refused
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			undef_instr <= 1'b0;
		end else begin
			undef_instr <= accept & in_illegal;
		end
	end

	// ----------------------------------------
	// operand outputs to the alu
	// ----------------------------------------

	// hold operands stable through write-back
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			op_valid    <= 1'b0;
			alu_opcode  <= 4'h0;
			op1         <= 32'h00000000;
			op2         <= 32'h00000000;
			shift_carry <= 1'b0;
		end else if (state == BSOP_EXEC) begin
			op_valid    <= 1'b1;
			alu_opcode  <= q_op;
			op1         <= opnd_q[0];
			op2         <= sel_op2;
			shift_carry <= sel_carry;
		end else begin
			op_valid    <= 1'b0;
		end
	end

	// ----------------------------------------
	// write-back
	// ----------------------------------------

	// destination register write
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rd_we    <= 1'b0;
			rd_index <= 4'h0;
			rd_value <= 32'h00000000;
		end else begin
			rd_we <= (state == BSOP_WB) & wb_rd;
			if (state == BSOP_WB) begin
				rd_index <= q_rd;
				rd_value <= alu_result;
			end
		end
	end

	// program counter write
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pc_we    <= 1'b0;
			pc_value <= 32'h00000000;
		end else begin
			pc_we <= (state == BSOP_WB) & wb_pc;
			if ((state == BSOP_WB) & wb_pc) begin
				pc_value <= alu_result;
			end
		end
	end

	// status word: restore, flag update or unchanged
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			current_status_word <= `BSOP_STATUS_RST;
		end else if (state == BSOP_WB) begin
			if (wb_restore) begin
				current_status_word <= saved_status_word;
			end else if (wb_flags) begin
				current_status_word[`BSOP_N:`BSOP_V] <= next_nzcv;
			end
		end
	end

	// ----------------------------------------
	// cycle cost report
	// ----------------------------------------

	// counts latched in write-back, with the completion pulse or two cycles before it on a pc write
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			done         <= 1'b0;
			cyc_seq      <= 2'h0;
			cyc_nonseq   <= 1'b0;
			cyc_internal <= 1'b0;
		end else begin
			done <= ((state == BSOP_WB) & ~wb_pc) | (state == BSOP_PC_N);
			if (state == BSOP_WB) begin
				cyc_seq      <= wb_pc ? `BSOP_CYC_S_PC : `BSOP_CYC_S_BASE;
				cyc_nonseq   <= wb_pc;
				cyc_internal <= q_shreg;
			end
		end
	end
endmodule

// ==== hw/bsop_defines.svh ====
`ifndef BSOP_DEFINES_SVH
`define BSOP_DEFINES_SVH

// instruction fields
`define BSOP_F_IMM      25
`define BSOP_F_OP_HI    24
`define BSOP_F_OP_LO    21
`define BSOP_F_SET      20
`define BSOP_F_RN_HI    19
`define BSOP_F_RN_LO    16
`define BSOP_F_RD_HI    15
`define BSOP_F_RD_LO    12
`define BSOP_F_RS_HI    11
`define BSOP_F_RS_LO    8
`define BSOP_F_AMT_HI   11
`define BSOP_F_AMT_LO   7
`define BSOP_F_TYP_HI   6
`define BSOP_F_TYP_LO   5
`define BSOP_F_SHREG    4
`define BSOP_F_MULBIT   7
`define BSOP_F_RM_HI    3
`define BSOP_F_RM_LO    0
// status word bits and values
`define BSOP_N          31
`define BSOP_Z          30
`define BSOP_C          29
`define BSOP_V          28
`define BSOP_MODE_HI    4
`define BSOP_MODE_USER  5'h10
`define BSOP_STATUS_RST 32'h000000D3
`define BSOP_PC_INDEX   4'hF
`define BSOP_OP_TEQ     4'h9
// prefetch offsets and cycle counts
`define BSOP_PC_OFS_IMM 32'h00000008
`define BSOP_PC_OFS_REG 32'h0000000C
`define BSOP_CYC_S_BASE 2'h1
`define BSOP_CYC_S_PC   2'h2
`endif

// ==== hw/bsop_pkg.sv ====
package bsop_pkg;
	typedef enum logic [1:0] {
		BSOP_LSL = 2'h0,
		BSOP_LSR = 2'h1,
		BSOP_ASR = 2'h2,
		BSOP_ROR = 2'h3
	} bsop_shift_t;

	// gray coded along idle, shift, exec, writeback, refill
	typedef enum logic [2:0] {
		BSOP_IDLE  = 3'h0,
		BSOP_RSH   = 3'h1,
		BSOP_EXEC  = 3'h3,
		BSOP_WB    = 3'h2,
		BSOP_PC_S  = 3'h6,
		BSOP_PC_N  = 3'h7
	} bsop_state_t;
endpackage

// ==== hw/bsop_shift_if.sv ====
`timescale 1ns/100ps
interface bsop_shift_if;
	import bsop_pkg::*;
	bsop_shift_t kind;
	logic [7:0]  amount;
	logic        imm_form;
	logic [31:0] value;
	logic        carry_in;
	logic [31:0] result;
	logic        carry_out;

	modport shifter (input kind, amount, imm_form, value, carry_in, output result, carry_out);
	modport client (output kind, amount, imm_form, value, carry_in, input result, carry_out);
endinterface

// ==== hw/bsop_shifter.sv ====
`timescale 1ns/100ps
module bsop_shifter
	import bsop_pkg::*;
#(
	parameter int W = 32
) (
	bsop_shift_if.shifter sh
);
	if (W != 32) begin : g_chk
		$error("bsop_shifter serves only a 32-bit datapath");
	end

	// immediate zero amounts are special encodings
	wire        amt_zero = (sh.amount == 8'h00);
	wire        imm_zero = sh.imm_form & amt_zero;
	wire        above32  = (sh.amount > 8'h20);
	wire [5:0]  amt6     = sh.amount[5:0];
	wire [5:0]  asr_amt  = (sh.amount >= 8'h20) ? 6'h20 : amt6;
	wire [4:0]  rot      = sh.amount[4:0];
	wire [32:0] lsl_ext  = {1'b0, sh.value} << amt6;
	wire [32:0] lsr_ext  = {sh.value, 1'b0} >> (imm_zero ? 6'h20 : amt6);
	wire [32:0] asr_ext  = 33'($signed({sh.value, 1'b0}) >>> (imm_zero ? 6'h20 : asr_amt));
	wire [63:0] ror_ext  = {sh.value, sh.value} >> rot;

	// operand two and carry, same cycle as selection
	always_comb begin
		sh.result    = sh.value;
		sh.carry_out = sh.carry_in;
		case (sh.kind)
			BSOP_LSL: begin
				if (amt_zero) begin
					sh.result    = sh.value;
					sh.carry_out = sh.carry_in;
				end else if (above32) begin
					sh.result    = 32'h00000000;
					sh.carry_out = 1'b0;
				end else begin
					sh.result    = lsl_ext[31:0];
					sh.carry_out = lsl_ext[32];
				end
			end
			BSOP_LSR: begin
				if (amt_zero & ~sh.imm_form) begin
					sh.result    = sh.value;
					sh.carry_out = sh.carry_in;
				end else if (above32) begin
					sh.result    = 32'h00000000;
					sh.carry_out = 1'b0;
				end else begin
					sh.result    = lsr_ext[32:1];
					sh.carry_out = lsr_ext[0];
				end
			end
			BSOP_ASR: begin
				if (amt_zero & ~sh.imm_form) begin
					sh.result    = sh.value;
					sh.carry_out = sh.carry_in;
				end else begin
					sh.result    = asr_ext[32:1];
					sh.carry_out = asr_ext[0];
				end
			end
			default: begin
				if (imm_zero) begin
					sh.result    = {sh.carry_in, sh.value[31:1]};
					sh.carry_out = sh.value[0];
				end else if (amt_zero) begin
					sh.result    = sh.value;
					sh.carry_out = sh.carry_in;
				end else begin
					sh.result    = ror_ext[31:0];
					sh.carry_out = ror_ext[31];
				end
			end
		endcase
	end
endmodule

// ==== hw/bsop_imm_rot.sv ====
`timescale 1ns/100ps
module bsop_imm_rot (
	input  wire logic [7:0]  imm,
	input  wire logic [3:0]  rot_field,
	input  wire logic        carry_in,
	output logic      [31:0] value,
	output logic             carry_out
);
	// rotate right by twice the field
	wire [4:0]  amt = {rot_field, 1'b0};
	wire [63:0] ext = {24'h000000, imm, 24'h000000, imm} >> amt;

	assign value     = ext[31:0];
	assign carry_out = (rot_field == 4'h0) ? carry_in : ext[31];
endmodule

// ==== dv/bsop_alu_model.sv ====
`timescale 1ns/100ps
// ----
// alu partner
// ----
module bsop_alu_model (
	input  wire logic [3:0]  alu_opcode,
	input  wire logic [31:0] op1,
	input  wire logic [31:0] op2,
	input  wire logic        carry_in,
	output logic      [31:0] alu_result,
	output logic             alu_carry,
	output logic             alu_overflow
);
	logic [31:0] a, b;
	logic        ci;
	logic [32:0] sum;

	// adder operand steering, then logic or sum select
	always_comb begin
		a = op1;
		b = op2;
		ci = 1'b0;
		case (alu_opcode)
			4'h2, 4'hA: begin b = ~op2; ci = 1'b1; end
			4'h3: begin a = op2; b = ~op1; ci = 1'b1; end
			4'h5: ci = carry_in;
			4'h6: begin b = ~op2; ci = carry_in; end
			4'h7: begin a = op2; b = ~op1; ci = carry_in; end
			default: ;
		endcase
		sum = {1'b0, a} + {1'b0, b} + {32'h0, ci};
		case (alu_opcode)
			4'h0, 4'h8: alu_result = op1 & op2;
			4'h1, 4'h9: alu_result = op1 ^ op2;
			4'hC: alu_result = op1 | op2;
			4'hD: alu_result = op2;
			4'hE: alu_result = op1 & ~op2;
			4'hF: alu_result = ~op2;
			default: alu_result = sum[31:0];
		endcase
		alu_carry = sum[32];
		alu_overflow = (a[31] == b[31]) && (sum[31] != a[31]);
	end
endmodule

// ==== dv/bsop_top_chk_sva.sv ====
`timescale 1ns/100ps
module bsop_top_chk (
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic        instr_valid,
	input wire logic [31:0] instr,
	input wire logic [31:0] instr_addr,
	input wire logic [31:0] alu_result,
	input wire logic [31:0] saved_status_word,
	input wire logic        instr_ready,
	input wire logic        op_valid,
	input wire logic [31:0] op1,
	input wire logic        pc_we,
	input wire logic [31:0] pc_value,
	input wire logic [31:0] current_status_word,
	input wire logic        undef_instr,
	input wire logic        done,
	input wire logic [1:0]  cyc_seq,
	input wire logic        cyc_nonseq,
	input wire logic        cyc_internal
);
	// ----
	// taken instruction
	// ----
	logic [31:0] c_ins, c_adr;
	wire         take  = instr_valid && instr_ready;
	wire         n_reg = !instr[25] && instr[4];
	wire         c_reg = !c_ins[25] && c_ins[4];
	wire         rd_pc = c_ins[15:12] == 4'hF;
	wire         pcw   = rd_pc && c_ins[24:23] != 2'b10;
	wire         s_bit = c_ins[20];

	// hold fields until the next take
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			c_ins <= 32'h0;
			c_adr <= 32'h0;
		end else if (take) begin
			c_ins <= instr;
			c_adr <= instr_addr;
		end
	end
	// ----
	// properties
	// ----
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence plain_end;
		##1 done && cyc_seq == 2'h1 && !cyc_nonseq && cyc_internal == c_reg;
	endsequence
	sequence pc_end;
		##1 pc_we ##2 done && cyc_seq == 2'h2 && cyc_nonseq && cyc_internal == c_reg;
	endsequence
	undef_pulse_a: assert property (take && n_reg && instr[7] |=> undef_instr)
		else $error("refused form not flagged");
	ready_drop_a: assert property (take && !(n_reg && instr[7]) |=> !instr_ready)
		else $error("ready kept after take");
	imm_latency_a: assert property (take && !n_reg |-> ##2 op_valid)
		else $error("operands late");
	reg_latency_a: assert property (take && n_reg && !instr[7] |-> ##3 op_valid)
		else $error("register shift operands late");
	plain_cost_a: assert property (op_valid && !pcw |-> plain_end)
		else $error("plain cost wrong");
	pc_cost_a: assert property (op_valid && pcw |-> pc_end)
		else $error("pc write cost wrong");
	pc_keep_a: assert property (op_valid && pcw && !s_bit |=>
		pc_value == $past(alu_result) && $stable(current_status_word))
		else $error("pc write disturbed status");
	pc_restore_a: assert property (op_valid && pcw && s_bit |=>
		current_status_word == $past(saved_status_word))
		else $error("status not restored");
	teq_restore_a: assert property (op_valid && rd_pc && s_bit && c_ins[24:21] == 4'h9 |=>
		current_status_word == (($past(current_status_word[4:0]) == 5'h10) ?
		$past(current_status_word) : $past(saved_status_word)))
		else $error("test restore wrong");
	pc_operand_a: assert property (op_valid && c_ins[19:16] == 4'hF |->
		op1 == c_adr + (c_reg ? 32'h0000000C : 32'h00000008))
		else $error("pc operand offset wrong");
endmodule

bind bsop_top bsop_top_chk i_chk (.ref_clk, .rst, .instr_valid, .instr, .instr_addr, .alu_result,
	.saved_status_word, .instr_ready, .op_valid, .op1, .pc_we, .pc_value, .current_status_word,
	.undef_instr, .done, .cyc_seq, .cyc_nonseq, .cyc_internal);

// ==== dv/bsop_top_tb.sv ====
`timescale 1ns/100ps
module bsop_top_tb;
	import bsop_pkg::*;
	// ----
	// signals
	// ----
	logic        ref_clk = 1'b0, rst = 1'b1, instr_valid = 1'b0, cflag = 1'b0;
	logic [31:0] instr = 32'h0, instr_addr = 32'h0, rn_value = 32'h0;
	logic [31:0] rm_value = 32'h0, rs_value = 32'h0, saved_status_word = 32'h0;
	logic [31:0] alu_result, op1, op2, rd_value, pc_value, current_status_word;
	logic        alu_carry, alu_overflow, instr_ready, op_valid, shift_carry, rd_we, pc_we;
	logic        undef_instr, done, cyc_nonseq, cyc_internal;
	logic [3:0]  alu_opcode, rd_index;
	logic [1:0]  cyc_seq;
	logic [32:0] exp_q[$];
	logic [32:0] mon_e;
	int          num_errors = 0, cmp_count = 0, cycles = 0;

	bsop_top i_dut (.ref_clk, .rst, .instr_valid, .instr, .instr_addr, .rn_value, .rm_value,
		.rs_value, .alu_result, .alu_carry, .alu_overflow, .saved_status_word, .instr_ready,
		.op_valid, .alu_opcode, .op1, .op2, .shift_carry, .rd_we, .rd_index, .rd_value, .pc_we,
		.pc_value, .current_status_word, .undef_instr, .done, .cyc_seq, .cyc_nonseq, .cyc_internal);
	bsop_alu_model i_alu (.alu_opcode, .op1, .op2, .carry_in(current_status_word[29]), .alu_result,
		.alu_carry, .alu_overflow);

	// clock and cycle ceiling
	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles > 3000) begin
			num_errors++;
			end_of_test();
		end
	end
	// ----
	// helpers
	// ----
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		cmp_count++;
		if (seen !== want) begin
			num_errors++;
			$display("unexpected at %0t: %h not %h", $time, seen, want);
		end
	endtask
	task automatic end_of_test();
		$display("compares %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	function automatic logic [31:0] mk(input logic i, input logic [3:0] op, input logic s,
		input logic [3:0] rn, input logic [3:0] rd, input logic [11:0] o2);
		return {4'hE, 2'b00, i, op, s, rn, rd, o2};
	endfunction
	// expected operand two and carry of a shift
	function automatic logic [32:0] ref_sh(input logic [1:0] k, input logic [7:0] a,
		input logic im, input logic [31:0] v);
		logic [63:0] d;
		if (a == 8'h00) begin
			if (!im || k == 2'h0) return {cflag, v};
			if (k == 2'h1) return {v[31], 32'h0};
			if (k == 2'h2) return {33{v[31]}};
			return {v[0], cflag, v[31:1]};
		end
		case (k)
			2'h0: d = {32'h0, v} << a;
			2'h1: d = {v, 32'h0} >> a;
			2'h2: d = $signed({v, 32'h0}) >>> a;
			default: d = {v, v} >> a[4:0];
		endcase
		if (k == 2'h0) return (a > 8'h20) ? 33'h0 : {d[32], d[31:0]};
		if (k == 2'h1) return (a > 8'h20) ? 33'h0 : {d[31], d[63:32]};
		if (k == 2'h2) return {d[31], d[63:32]};
		return (a[4:0] == 5'h0) ? {v[31], v} : {d[31], d[31:0]};
	endfunction
	function automatic logic [32:0] ref_imm(input logic [3:0] r, input logic [7:0] m);
		logic [63:0] d;
		d = {24'h0, m, 24'h0, m} >> {r, 1'b0};
		return {(r == 4'h0) ? cflag : d[31], d[31:0]};
	endfunction
	// offer one instruction and wait for its end
	task automatic issue(input logic [31:0] ins, input logic [31:0] rn, input logic [31:0] rm,
		input logic [31:0] rs, input logic [32:0] ex, input logic [31:0] sv, input logic bad);
		int n;
		@(posedge ref_clk);
		instr_valid <= 1'b1;
		instr <= ins;
		instr_addr <= $urandom & 32'hFFFFFFFC;
		rn_value <= rn;
		rm_value <= rm;
		rs_value <= rs;
		saved_status_word <= sv;
		if (!bad) exp_q.push_back(ex);
		@(posedge ref_clk);
		instr_valid <= 1'b0;
		n = 0;
		#1;
		while (done !== 1'b1 && undef_instr !== 1'b1 && n < 20) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		check({31'h0, undef_instr}, {31'h0, bad});
		check({31'h0, done}, {31'h0, ~bad});
		if (!bad)
			check({31'h0, rd_we}, {31'h0, ins[15:12] != 4'hF && ins[24:23] != 2'b10});
	endtask
	task automatic sweep();
		logic [7:0]  am[7];
		logic [31:0] v;
		logic [7:0]  a;
		am = '{8'h00, 8'h01, 8'h1F, 8'h20, 8'h21, 8'hFF, 8'h00};
		for (int k = 0; k < 4; k++) begin
			for (int i = 0; i < 7; i++) begin
				v = $urandom;
				a = (i == 6) ? 8'($urandom) : am[i];
				issue(mk(1'b0, 4'hD, 1'b0, 4'($urandom), 4'h1, {4'h2, 1'b0, 2'(k), 1'b1, 4'h3}),
					$urandom, v, {24'($urandom), a}, ref_sh(2'(k), a, 1'b0, v), $urandom, 1'b0);
				issue(mk(1'b0, 4'hD, 1'b0, 4'($urandom), 4'h1, {a[4:0], 2'(k), 1'b0, 4'h3}),
					$urandom, v, $urandom, ref_sh(2'(k), {3'h0, a[4:0]}, 1'b1, v), $urandom, 1'b0);
			end
		end
		for (int r = 0; r < 16; r++) begin
			v = $urandom;
			issue(mk(1'b1, 4'hD, 1'b0, 4'($urandom), 4'h1, {4'(r), v[7:0]}), $urandom, v, v,
				ref_imm(4'(r), v[7:0]), v, 1'b0);
		end
	endtask
	// ----
	// operand monitor
	// ----
	always @(posedge ref_clk) begin
		if (op_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				check(32'h1, 32'h0);
			end else begin
				mon_e = exp_q.pop_front();
				check(op2, mon_e[31:0]);
				check({31'h0, shift_carry}, {31'h0, mon_e[32]});
			end
		end
	end
	// ----
	// main sequence
	// ----
	initial begin
		void'($urandom(32'h65c4));
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		sweep();
		issue(mk(1'b1, 4'hD, 1'b1, 4'h0, 4'hF, 12'h040), 0, 0, 0, {cflag, 32'h40}, 32'h200000D3, 0);
		check(current_status_word, 32'h200000D3);
		cflag = 1'b1;
		sweep();
		issue(mk(1'b0, 4'hD, 1'b0, 4'h0, 4'hF, 12'h213), 0, 1, 4, {1'b0, 32'h10}, 0, 0);
		check(current_status_word, 32'h200000D3);
		issue(mk(1'b1, 4'h9, 1'b1, 4'h0, 4'hF, 12'h001), 0, 0, 0, {1'b1, 32'h1}, 32'h6000001F, 0);
		check(current_status_word, 32'h6000001F);
		issue(mk(1'b1, 4'hD, 1'b1, 4'h0, 4'hF, 12'h080), 0, 0, 0, {1'b1, 32'h80}, 32'h00000010, 0);
		check(current_status_word, 32'h00000010);
		issue(mk(1'b1, 4'h9, 1'b1, 4'h0, 4'hF, 12'h001), 0, 0, 0, {1'b0, 32'h1}, 32'hF00000D3, 0);
		check(current_status_word, 32'h00000010);
		issue(mk(1'b0, 4'hD, 1'b1, 4'h0, 4'h1, 12'h023), 0, 32'h80000000, 0, {1'b1, 32'h0}, 0, 0);
		check(current_status_word, 32'h60000010);
		cflag = 1'b1;
		issue(mk(1'b1, 4'h4, 1'b1, 4'h2, 4'h1, 12'h001), 32'h7FFFFFFF, 0, 0, {1'b1, 32'h1}, 0, 0);
		check(current_status_word, 32'h90000010);
		check(rd_value, 32'h80000000);
		check({28'h0, rd_index}, 32'h00000001);
		check({28'h0, alu_opcode}, 32'h00000004);
		check(op1, 32'h7FFFFFFF);
		issue(mk(1'b0, 4'hD, 1'b0, 4'h0, 4'h1, 12'h293), 0, 0, 0, 33'h0, 0, 1);
		repeat (4) @(posedge ref_clk);
		check(32'(exp_q.size()), 32'h0);
		end_of_test();
	end
endmodule
